// ### rtl/frs_pkg.sv
/*
  frs_pkg: constants, register map and carrier types for the fault
  response and sync supervision block.
  Assumes a 100 MHz clock and a 32-bit Avalon-MM register port.
*/
package frs_pkg;
  // clock
  localparam int CLK_MHZ = 100;
  localparam int CLK_NS  = 10;

  // timing figures as printed, then cycle counts
  localparam int SYNC_LOW_NS   = 500;
  localparam int SYNC_LOW_CYC  = SYNC_LOW_NS / CLK_NS;
  localparam int TB_PERIOD_US  = 10;
  localparam int TB_LOW_US     = 1;
  localparam int TB_PERIOD_CYC = TB_PERIOD_US * CLK_MHZ;
  localparam int TB_LOW_CYC    = TB_LOW_US * CLK_MHZ;
  localparam int MIN_ON_NS     = 45;
  localparam int MIN_ON_CYC    = (MIN_ON_NS + CLK_NS - 1) / CLK_NS;

  // sync frequency window: 250 kHz .. 1 MHz, as period in cycles
  localparam int SYNC_MIN_KHZ  = 250;
  localparam int SYNC_MAX_KHZ  = 1000;
  localparam int SYNC_MAX_PCYC = (CLK_MHZ * 1000) / SYNC_MIN_KHZ;
  localparam int SYNC_MIN_PCYC = (CLK_MHZ * 1000) / SYNC_MAX_KHZ;
  // lowest free-running loop frequency, used with CTRL_EXT_OSC set when external sync is not followed
  localparam int FREE_LOW_KHZ  = SYNC_MIN_KHZ;
  localparam int FREE_LOW_PCYC = (CLK_MHZ * 1000) / FREE_LOW_KHZ;
  // lock tolerance in cycles between consecutive sync periods
  localparam logic [11:0] LOCK_TOL = 12'h004;

  // temperature thresholds, whole degrees C
  localparam logic [7:0] TEMP_BLOCK_C   = 8'h82;
  localparam logic [7:0] TEMP_RELEASE_C = 8'h7D;
  localparam logic [7:0] TEMP_ADVISE_C  = 8'h55;

  // register byte addresses (word index times four)
  localparam logic [5:0] ADDR_CTRL    = 6'h00;
  localparam logic [5:0] ADDR_FCFG    = 6'h04;
  localparam logic [5:0] ADDR_RETRY   = 6'h08;
  localparam logic [5:0] ADDR_PWMCFG  = 6'h0C;
  localparam logic [5:0] ADDR_VSTAT   = 6'h10;
  localparam logic [5:0] ADDR_PADS    = 6'h14;
  localparam logic [5:0] ADDR_ALMASK  = 6'h18;
  localparam logic [5:0] ADDR_FSTAT   = 6'h1C;
  localparam logic [5:0] ADDR_PEAK    = 6'h20;
  localparam logic [5:0] ADDR_LOG     = 6'h24;
  localparam logic [5:0] ADDR_PERIOD  = 6'h28;
  localparam logic [5:0] ADDR_NVM     = 6'h2C;

  // field positions
  localparam int CTRL_LOG_EN   = 0;
  localparam int CTRL_SYNC_OE  = 1;
  localparam int CTRL_EXT_OSC  = 2;
  localparam int CTRL_RUN0     = 3;
  localparam int CTRL_RUN1     = 4;
  localparam int VSTAT_PLL     = 4;
  localparam int PADS_SYNC_CLK = 10;
  localparam int ALMASK_PLL    = 4;
  localparam int PHASE_W       = 3;

  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0018;
  localparam logic [31:0] FCFG_RST   = 32'h0000_0000;
  localparam logic [15:0] RETRY_RST  = 16'h03E8;
  localparam logic [11:0] PERIOD_RST = 12'h0C8;

  // fault sources
  localparam int NSRC = 7;
  localparam int SRC_OV = 0;
  localparam int SRC_UV = 1;
  localparam int SRC_OC = 2;
  localparam int SRC_OT = 3;
  localparam int SRC_TM = 4;
  localparam int SRC_PK = 5;
  localparam int SRC_EX = 6;

  typedef enum logic [1:0] {
    RESP_IGNORE = 2'b00,
    RESP_LATCH  = 2'b01,
    RESP_RETRY  = 2'b10
  } frs_resp_t;

  typedef enum logic [1:0] {
    CH_OFF   = 2'b00,
    CH_RUN   = 2'b01,
    CH_LATCH = 2'b10,
    CH_WAIT  = 2'b11
  } frs_ch_state_t;

  // per-channel analog fault inputs
  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic ot;
    logic tm;
    logic pk;
  } frs_flt_t;

  // per-channel gate command
  typedef struct packed {
    logic hs;
    logic ls;
  } frs_gate_t;
endpackage

// ### rtl/frs_channel.sv
/*
  frs_channel: fault response sequencer for one output channel.
  Assumes synchronised fault levels and register settings from the
  parent; all inputs are on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module frs_channel
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // settings
  input  wire logic                  run,
  input  wire logic [13:0]           resp,
  input  wire logic [15:0]           retry_us,
  // fault levels
  input  wire logic [6:0]            fault,
  // pwm request from the loop
  input  wire logic                  pwm_req,
  input  wire logic [7:0]            on_cyc,
  // results
  output logic                       active,
  output logic                       trip,
  output frs_pkg::frs_gate_t         gate,
  output logic                       skip
);
  frs_pkg::frs_ch_state_t state;
  frs_pkg::frs_ch_state_t next_state;
  logic [6:0]  hit_latch;
  logic [6:0]  hit_retry;
  logic [22:0] wait_cnt;
  logic [22:0] wait_len;
  logic        any_latch;
  logic        any_retry;

  // decode the two-bit response code of each source
  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : g_src
      assign hit_latch[g] = fault[g] && (resp[2*g+1:2*g] == frs_pkg::RESP_LATCH);
      assign hit_retry[g] = fault[g] && (resp[2*g+1:2*g] == frs_pkg::RESP_RETRY);
    end
  endgenerate

  assign any_latch = |hit_latch;
  assign any_retry = |hit_retry;
  assign wait_len  = 23'(retry_us) * 23'(frs_pkg::CLK_MHZ);
  assign trip      = (state == frs_pkg::CH_RUN) && (any_latch || any_retry);
  assign active    = (state == frs_pkg::CH_RUN);

  // latch-off outranks retry when both respond at once
  always_comb
  begin
    next_state = state;
    case (state)
      frs_pkg::CH_OFF:   if (run) next_state = frs_pkg::CH_RUN;
      frs_pkg::CH_RUN:
      begin
        if (!run)           next_state = frs_pkg::CH_OFF;
        else if (any_latch) next_state = frs_pkg::CH_LATCH;
        else if (any_retry) next_state = frs_pkg::CH_WAIT;
      end
      frs_pkg::CH_LATCH: if (!run) next_state = frs_pkg::CH_OFF;
      frs_pkg::CH_WAIT:
      begin
        if (!run)                      next_state = frs_pkg::CH_OFF;
        else if (wait_cnt >= wait_len) next_state = frs_pkg::CH_RUN;  // retries never run out
      end
      default:           next_state = frs_pkg::CH_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= frs_pkg::CH_OFF;
    else
      state <= next_state;
  end

  // retry interval counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_cnt <= '0;
    else if (state == frs_pkg::CH_WAIT)
      wait_cnt <= wait_cnt + 23'h1;
    else
      wait_cnt <= '0;
  end

  // gate drive: overvoltage overrides everything, no software involved
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate <= '0;
      skip <= 1'b0;
    end
    else
    begin
      skip <= pwm_req && (on_cyc < 8'(frs_pkg::MIN_ON_CYC));
      if (fault[frs_pkg::SRC_OV])
        gate <= '{hs: 1'b0, ls: 1'b1};
      else if (state != frs_pkg::CH_RUN)
        gate <= '0;   // three-state: both off
      else if (pwm_req && on_cyc >= 8'(frs_pkg::MIN_ON_CYC))
        gate <= '{hs: 1'b1, ls: 1'b0};
      else
        gate <= '{hs: 1'b0, ls: 1'b1};   // skipped cycle keeps low side on
    end
  end
endmodule
`default_nettype wire

// ### rtl/frs_top.sv
/*
  frs_top: fault response, fault log, memory temperature lockout and
  sync phase-lock supervision for a dual-channel regulator controller.
  Assumes a 100 MHz clk, an Avalon-MM master on the register port, and
  external pull-ups on the open-drain pins it drives.
*/
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module frs_top
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // avalon-mm register slave
  input  wire logic [5:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  // analog comparator levels, per channel
  input  wire frs_pkg::frs_flt_t     flt0,
  input  wire frs_pkg::frs_flt_t     flt1,
  input  wire logic                  vin_ok,
  input  wire logic [7:0]            die_temp,
  input  wire logic [11:0]           peak_meas,
  // pwm loop requests
  input  wire logic                  pwm_req0,
  input  wire logic                  pwm_req1,
  input  wire logic [7:0]            on_cyc0,
  input  wire logic [7:0]            on_cyc1,
  // memory access requests
  input  wire logic                  nvm_req,
  input  wire logic                  nvm_restore,
  output logic                       nvm_grant,
  // open-drain fault pins
  input  wire logic [1:0]            fault_signal_pin_n_in,
  output logic [1:0]                 fault_signal_pin_n_oe,
  // open-drain sync line
  input  wire logic                  sync_in,
  output logic                       sync_oe,
  // open-drain timebase line
  output logic                       timebase_oe,
  // open-drain alert line
  output logic                       alert_oe,
  // gate drive
  output frs_pkg::frs_gate_t         gate0,
  output frs_pkg::frs_gate_t         gate1,
  output logic                       skip0,
  output logic                       skip1,
  // phase-aligned channel clock ticks
  output logic                       ch_tick0,
  output logic                       ch_tick1
);
  // registers
  logic [31:0] ctrl;
  logic [31:0] fcfg;
  logic [15:0] retry;
  logic [2:0]  phase;
  logic [31:0] alert_mask;
  logic [11:0] nominal_period;
  logic        pll_lost;
  logic [11:0] peak;
  logic [15:0] log_rec;
  logic        log_valid;
  logic        nvm_block;
  logic        rd_hold;
  logic        sync_arm;
  // synchronisers
  logic [1:0]  fpin_s1;
  logic [1:0]  fpin_s2;
  logic        sync_s1;
  logic        sync_s2;
  logic        sync_d;
  logic        vin_s1;
  logic        vin_s2;
  // pll
  logic [11:0] sync_cnt;
  logic [11:0] sync_per;
  logic        sync_seen;
  logic        locked;
  logic [11:0] osc_cnt;
  logic [11:0] osc_per;
  logic [11:0] tb_cnt;
  // channels
  logic        act0;
  logic        act1;
  logic        trip0;
  logic        trip1;
  logic        trip_d;
  logic [6:0]  fv0;
  logic [6:0]  fv1;

  // bus decode
  wire         wr_ctrl   = avs_write && avs_address == frs_pkg::ADDR_CTRL;
  wire         wr_fcfg   = avs_write && avs_address == frs_pkg::ADDR_FCFG;
  wire         wr_retry  = avs_write && avs_address == frs_pkg::ADDR_RETRY;
  wire         wr_pwm    = avs_write && avs_address == frs_pkg::ADDR_PWMCFG;
  wire         wr_vstat  = avs_write && avs_address == frs_pkg::ADDR_VSTAT;
  wire         wr_mask   = avs_write && avs_address == frs_pkg::ADDR_ALMASK;
  wire         wr_period = avs_write && avs_address == frs_pkg::ADDR_PERIOD;
  wire [31:0]  be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // reads stall one cycle so the registered data stands when waitrequest drops
  assign avs_waitrequest = avs_read && !rd_hold;

  // pin synchronisers: first stage only feeds second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fpin_s1 <= 2'b11;
      fpin_s2 <= 2'b11;
      sync_s1 <= 1'b1;
      sync_s2 <= 1'b1;
      sync_d  <= 1'b1;
      vin_s1  <= 1'b0;
      vin_s2  <= 1'b0;
    end
    else
    begin
      fpin_s1 <= fault_signal_pin_n_in;
      fpin_s2 <= fpin_s1;
      sync_s1 <= sync_in;
      sync_s2 <= sync_s1;
      sync_d  <= sync_s2;
      vin_s1  <= vin_ok;
      vin_s2  <= vin_s1;
    end
  end

  // fault vectors: analog sources plus external low on the pin
  assign fv0 = {~fpin_s2[0], flt0.pk, flt0.tm, flt0.ot, flt0.oc, flt0.uv, flt0.ov};
  assign fv1 = {~fpin_s2[1], flt1.pk, flt1.tm, flt1.ot, flt1.oc, flt1.uv, flt1.ov};

  // fault pin pulls low when any selected source of its channel is active
  // (fcfg[28:16] selects channel 0 bits 21:16, channel 1 bits 28:23)
  assign fault_signal_pin_n_oe[0] = |(fv0[5:0] & fcfg[21:16]);
  assign fault_signal_pin_n_oe[1] = |(fv1[5:0] & fcfg[28:23]);

  frs_channel u_ch0
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (ctrl[frs_pkg::CTRL_RUN0] && vin_s2),
    .resp     (fcfg[13:0]),
    .retry_us (retry),
    .fault    (fv0),
    .pwm_req  (pwm_req0),
    .on_cyc   (on_cyc0),
    .active   (act0),
    .trip     (trip0),
    .gate     (gate0),
    .skip     (skip0)
  );

  frs_channel u_ch1
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (ctrl[frs_pkg::CTRL_RUN1] && vin_s2),
    .resp     (fcfg[13:0]),
    .retry_us (retry),
    .fault    (fv1),
    .pwm_req  (pwm_req1),
    .on_cyc   (on_cyc1),
    .active   (act1),
    .trip     (trip1),
    .gate     (gate1),
    .skip     (skip1)
  );

  // sync period measurement on the falling edge only; rising edges
  // cannot retune, so no harmonic lock; a glitch's falling edge in between still restarts the count
  wire sync_fall = sync_d && !sync_s2;
  wire in_range  = sync_cnt >= 12'(frs_pkg::SYNC_MIN_PCYC) && sync_cnt <= 12'(frs_pkg::SYNC_MAX_PCYC);
  wire per_close = (sync_cnt > sync_per ? sync_cnt - sync_per : sync_per - sync_cnt) <= frs_pkg::LOCK_TOL;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_cnt  <= '0;
      sync_per  <= '0;
      sync_seen <= 1'b0;
      locked    <= 1'b0;
    end
    else if (sync_fall)
    begin
      sync_cnt  <= 12'h001;
      sync_per  <= sync_cnt;
      sync_seen <= in_range;
      locked    <= in_range && per_close;
    end
    else if (sync_cnt > 12'(frs_pkg::SYNC_MAX_PCYC))
    begin
      sync_seen <= 1'b0;   // clock missing
      locked    <= 1'b0;
    end
    else
      sync_cnt <= sync_cnt + 12'h001;
  end

  // period: followed sync, else nominal or lowest free rate; our own drive never follows itself
  assign osc_per = (sync_seen && !ctrl[frs_pkg::CTRL_SYNC_OE]) ? sync_per :
                   ctrl[frs_pkg::CTRL_EXT_OSC] ? 12'(frs_pkg::FREE_LOW_PCYC) :
                   nominal_period;

  // oscillator restarts on each followed sync fall to hold a fixed phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_cnt <= '0;
    else if ((sync_fall && sync_seen && !ctrl[frs_pkg::CTRL_SYNC_OE]) || osc_cnt >= osc_per - 12'h001)
      osc_cnt <= '0;
    else
      osc_cnt <= osc_cnt + 12'h001;
  end

  // phase ticks in eighths of a period; ch1 lags by half
  wire [14:0] ph0 = 15'(osc_per) * 15'(phase) >> 3;
  wire [14:0] ph1 = 15'(osc_per) * 15'(3'(phase + 3'h4)) >> 3;
  assign ch_tick0 = 15'(osc_cnt) == ph0;
  assign ch_tick1 = 15'(osc_cnt) == ph1;
  // sync output and timebase; input undervoltage holds timebase low
  assign sync_oe = sync_arm && osc_cnt < 12'(frs_pkg::SYNC_LOW_CYC);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tb_cnt <= '0;
    else if (tb_cnt == 12'(frs_pkg::TB_PERIOD_CYC - 1))
      tb_cnt <= '0;
    else
      tb_cnt <= tb_cnt + 12'h001;
  end
  assign timebase_oe = !vin_s2 || tb_cnt < 12'(frs_pkg::TB_LOW_CYC);

  // lock-loss flag: set wins over the write-one clear, stays sticky
  wire lock_drop = locked && !in_range && sync_cnt > 12'(frs_pkg::SYNC_MAX_PCYC) ||
                   locked && sync_fall && !(in_range && per_close);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pll_lost <= 1'b0;
    else if (lock_drop && (act0 || act1))
      pll_lost <= 1'b1;
    else if (wr_vstat && avs_byteenable[0] && avs_writedata[frs_pkg::VSTAT_PLL])
      pll_lost <= 1'b0;
  end
  assign alert_oe = pll_lost && !alert_mask[frs_pkg::ALMASK_PLL];

  // memory lockout with hysteresis; restore is always let through
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      nvm_block <= 1'b0;
    else if (die_temp > frs_pkg::TEMP_BLOCK_C)
      nvm_block <= 1'b1;
    else if (die_temp < frs_pkg::TEMP_RELEASE_C)
      nvm_block <= 1'b0;
  end
  assign nvm_grant = nvm_req && (nvm_restore || !nvm_block);

  // peak tracking and fault log record on a shutdown trip
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      peak      <= '0;
      log_rec   <= '0;
      log_valid <= 1'b0;
      trip_d    <= 1'b0;
    end
    else
    begin
      trip_d <= trip0 || trip1;
      if (peak_meas > peak)
        peak <= peak_meas;
      if (ctrl[frs_pkg::CTRL_LOG_EN] && (trip0 || trip1) && !trip_d)
      begin
        log_rec   <= {fv1, fv0, trip1, trip0};
        log_valid <= 1'b1;
      end
    end
  end

  // register writes, read stall and sync drive arming at a period start
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl           <= frs_pkg::CTRL_RST;
      fcfg           <= frs_pkg::FCFG_RST;
      retry          <= frs_pkg::RETRY_RST;
      phase          <= '0;
      alert_mask     <= '0;
      nominal_period <= frs_pkg::PERIOD_RST;
      rd_hold        <= 1'b0;
      sync_arm       <= 1'b0;
    end
    else
    begin
      rd_hold <= avs_read && !rd_hold;
      if (osc_cnt >= osc_per - 12'h001) sync_arm <= ctrl[frs_pkg::CTRL_SYNC_OE];   // whole pulses only
      if (wr_ctrl)   ctrl  <= merge(ctrl, avs_writedata, be_mask);
      if (wr_fcfg)   fcfg  <= merge(fcfg, avs_writedata, be_mask);
      if (wr_retry)  retry <= 16'(merge({16'h0, retry}, avs_writedata, be_mask));
      if (wr_pwm && avs_byteenable[0]) phase <= avs_writedata[frs_pkg::PHASE_W-1:0];
      if (wr_mask)   alert_mask <= merge(alert_mask, avs_writedata, be_mask);
      if (wr_period) nominal_period <= 12'(merge({20'h0, nominal_period}, avs_writedata, be_mask));
    end
  end

  // read mux, registered data; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= '0;
    else if (avs_read)
      case (avs_address)
        frs_pkg::ADDR_CTRL:   avs_readdata <= ctrl;
        frs_pkg::ADDR_FCFG:   avs_readdata <= fcfg;
        frs_pkg::ADDR_RETRY:  avs_readdata <= {16'h0, retry};
        frs_pkg::ADDR_PWMCFG: avs_readdata <= {29'h0, phase};
        frs_pkg::ADDR_VSTAT:  avs_readdata <= 32'(pll_lost) << frs_pkg::VSTAT_PLL;
        frs_pkg::ADDR_PADS:   avs_readdata <= 32'(sync_seen) << frs_pkg::PADS_SYNC_CLK;
        frs_pkg::ADDR_ALMASK: avs_readdata <= alert_mask;
        frs_pkg::ADDR_FSTAT:  avs_readdata <= {22'h0, nvm_block, locked, act1, act0, fpin_s2, 2'b00, trip1, trip0};
        frs_pkg::ADDR_PEAK:   avs_readdata <= {20'h0, peak};
        frs_pkg::ADDR_LOG:    avs_readdata <= {15'h0, log_valid, log_rec};
        frs_pkg::ADDR_PERIOD: avs_readdata <= {20'h0, nominal_period};
        frs_pkg::ADDR_NVM:    avs_readdata <= {23'h0, nvm_block, die_temp};
        default:              avs_readdata <= '0;
      endcase
  end
endmodule
`default_nettype wire

// ### verif/frs_peer.sv
/*
  frs_peer: a peer controller that owns the shared sync line.
  Assumes the line has a pull-up, so it reads high whenever released.
*/
`timescale 1ns/10ps
`default_nettype none
module frs_peer
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        en,
  input  wire logic [11:0] period,
  // high = pull sync low
  output logic             pull
);
  logic [11:0] cnt;
  // period counter; a shrinking period restarts at once
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      cnt <= 12'h000;
    else if (!en || cnt >= period - 12'h001)
      cnt <= 12'h000;
    else
      cnt <= cnt + 12'h001;
  // only this peer drives while the block's own output is off
  assign pull = en && (cnt < 12'h032);
endmodule
`default_nettype wire

// ### verif/frs_checker.sv
/*
  frs_checker: port-level timing checks on frs_top.
  Assumes a single clock domain and the pull-ups outside the block.
*/
`timescale 1ns/10ps
`default_nettype none
module frs_checker
(
  // clock, reset, bus
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [5:0]         avs_address,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  // levels and results
  input wire frs_pkg::frs_flt_t  flt0,
  input wire frs_pkg::frs_flt_t  flt1,
  input wire frs_pkg::frs_gate_t gate0,
  input wire frs_pkg::frs_gate_t gate1,
  input wire logic               vin_ok,
  input wire logic [7:0]         die_temp,
  input wire logic               nvm_req,
  input wire logic               nvm_restore,
  input wire logic               nvm_grant,
  input wire logic               pwm_req0,
  input wire logic [7:0]         on_cyc0,
  input wire logic               skip0,
  input wire logic               sync_oe,
  input wire logic               timebase_oe,
  input wire logic               alert_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0]  s_cnt;
  logic [7:0]  t_cnt;
  logic [10:0] v_cnt;
  logic        mask;
  wire  logic  st_wr = avs_write && avs_address == frs_pkg::ADDR_VSTAT;
  wire  logic  mk_wr = avs_write && avs_address == frs_pkg::ADDR_ALMASK;
  // pulse widths, settled supply age and a copy of the alert mask
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s_cnt <= 8'h00;
      t_cnt <= 8'h00;
      v_cnt <= 11'h000;
      mask  <= 1'b0;
    end
    else
    begin
      s_cnt <= sync_oe ? s_cnt + 8'h01 : 8'h00;
      t_cnt <= timebase_oe ? t_cnt + 8'h01 : 8'h00;
      v_cnt <= !vin_ok ? 11'h000 : (v_cnt == 11'h7FF ? v_cnt : v_cnt + 11'h001);
      mask  <= mk_wr ? avs_writedata[frs_pkg::ALMASK_PLL] : mask;
    end
  ov_gate0_a: assert property (flt0.ov |=> !gate0.hs && gate0.ls) else $error("ch0 overvoltage gate");
  ov_gate1_a: assert property (flt1.ov |=> !gate1.hs && gate1.ls) else $error("ch1 overvoltage gate");
  sync_pulse_a: assert property ($fell(sync_oe) |-> s_cnt == frs_pkg::SYNC_LOW_CYC) else $error("sync width");
  tb_pulse_a: assert property ($fell(timebase_oe) && v_cnt > 11'h44C |-> t_cnt == frs_pkg::TB_LOW_CYC)
    else $error("timebase width");
  vin_hold_a: assert property (!vin_ok [*4] |-> timebase_oe) else $error("timebase not held");
  hot_block_a: assert property (die_temp > 8'h82 && $past(die_temp) > 8'h82 && nvm_req && !nvm_restore |-> !nvm_grant)
    else $error("memory not blocked");
  restore_ok_a: assert property (nvm_req && nvm_restore |-> nvm_grant) else $error("restore refused");
  skip_short_a: assert property (pwm_req0 && on_cyc0 < 8'(frs_pkg::MIN_ON_CYC) |=> skip0)
    else $error("no skip");
  alert_mask_a: assert property (mask |-> !alert_oe) else $error("masked alert seen");
  alert_stick_a: assert property (alert_oe && !st_wr && !mk_wr |=> alert_oe) else $error("alert dropped");
  cover property ($rose(alert_oe));
  cover property ($fell(sync_oe));
  cover property (flt0.ov);
endmodule
bind frs_top frs_checker chk_i (.clk, .rst_n, .avs_address, .avs_write, .avs_writedata, .flt0, .flt1, .gate0,
  .gate1, .vin_ok, .die_temp, .nvm_req, .nvm_restore, .nvm_grant, .pwm_req0, .on_cyc0, .skip0, .sync_oe,
  .timebase_oe, .alert_oe);
`default_nettype wire

// ### verif/tb.sv
/*
  tb: register-level scenarios for frs_top with one sync peer.
  Assumes pull-ups on all open-drain lines; the slave stalls reads by one cycle, never writes.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, vin_ok = 1'b0;
  logic pwm_req0 = 1'b0, pwm_req1 = 1'b0, nvm_req = 1'b0, nvm_restore = 1'b0, peer_en = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF;
  frs_pkg::frs_flt_t flt0 = '0, flt1 = '0;
  frs_pkg::frs_gate_t gate0, gate1;
  logic [7:0] die_temp = 8'h19, on_cyc0 = 8'h10, on_cyc1 = 8'h10;
  logic [11:0] peak_meas = 12'h123, peer_per = 12'h0C8;
  logic avs_waitrequest, nvm_grant, sync_oe, timebase_oe, alert_oe, skip0, skip1, ch_tick0, ch_tick1, pull;
  logic [1:0] fsp_oe;
  int errors = 0, tests_run = 0, ks, kt;
  // released open-drain lines read high
  wire logic sync_in = ~(pull | sync_oe);
  wire logic [1:0] fsp_in = ~fsp_oe;
  always #5 clk = ~clk;
  frs_top uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .flt0, .flt1, .vin_ok, .die_temp, .peak_meas, .pwm_req0, .pwm_req1, .on_cyc0, .on_cyc1,
    .nvm_req, .nvm_restore, .nvm_grant, .fault_signal_pin_n_in(fsp_in), .fault_signal_pin_n_oe(fsp_oe), .sync_in,
    .sync_oe, .timebase_oe, .alert_oe, .gate0, .gate1, .skip0, .skip1, .ch_tick0, .ch_tick1);
  frs_peer peer (.clk, .rst_n, .en(peer_en), .period(peer_per), .pull);
  task results;
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk);
      n = 0;
      while (avs_waitrequest !== 1'b0 && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      if (n == 100)
      begin
        errors++;
        results;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial
  begin
    cyc(3);
    rst_n <= 1'b1;
    vin_ok <= 1'b1;
    cyc(4);
    bus(0, frs_pkg::ADDR_RETRY, 0);
    chk(rd, 32'h3E8);
    bus(0, frs_pkg::ADDR_PEAK, 0);
    chk(rd, 32'h123);
    bus(0, 6'h3C, 0);
    chk(rd, 32'h0);
    // cycle skipping at the minimum on-time boundary
    pwm_req0 <= 1'b1;
    on_cyc0 <= 8'h04;
    cyc(4);
    chk(skip0, 1'b1);
    on_cyc0 <= 8'h05;
    cyc(4);
    chk(skip0, 1'b0);
    // memory lockout with hysteresis; restore always passes
    nvm_req <= 1'b1; // lockout probe only, no store issued while hot
    die_temp <= 8'h83;
    cyc(3);
    chk(nvm_grant, 1'b0);
    nvm_restore <= 1'b1;
    cyc(2);
    chk(nvm_grant, 1'b1);
    nvm_restore <= 1'b0;
    die_temp <= 8'h7E;
    cyc(3);
    chk(nvm_grant, 1'b0);
    die_temp <= 8'h7C;
    cyc(3);
    chk(nvm_grant, 1'b1);
    // lock, loss, sticky status, clear and mask
    peer_en <= 1'b1;
    cyc(1500);
    bus(0, frs_pkg::ADDR_PADS, 0);
    chk(rd[10], 1'b1);
    chk(alert_oe, 1'b0);
    peer_per <= 12'h140;
    cyc(1200);
    chk(alert_oe, 1'b1);
    peer_per <= 12'h0C8;
    cyc(1500);
    bus(0, frs_pkg::ADDR_VSTAT, 0);
    chk(rd[4], 1'b1);
    bus(1, frs_pkg::ADDR_VSTAT, 32'h10);
    bus(0, frs_pkg::ADDR_VSTAT, 0);
    chk(rd[4], 1'b0);
    chk(alert_oe, 1'b0);
    bus(1, frs_pkg::ADDR_ALMASK, 32'h10);
    peer_per <= 12'h140;
    cyc(1200);
    chk(alert_oe, 1'b0);
    bus(0, frs_pkg::ADDR_VSTAT, 0);
    chk(rd[4], 1'b1);
    peer_en <= 1'b0;
    cyc(1000);
    bus(0, frs_pkg::ADDR_PADS, 0);
    chk(rd[10], 1'b0);
    // own sync output and timebase duty over whole periods
    bus(1, frs_pkg::ADDR_CTRL, 32'h1B);
    cyc(600);
    ks = 0;
    kt = 0;
    repeat (1000)
    begin
      @(posedge clk);
      ks += sync_oe;
      kt += timebase_oe;
    end
    chk(ks, 250);
    chk(kt, 100);
    vin_ok <= 1'b0;
    cyc(5);
    chk(timebase_oe, 1'b1);
    vin_ok <= 1'b1;
    // overvoltage with latch-off response
    bus(1, frs_pkg::ADDR_FCFG, 32'h0001_0001);
    on_cyc0 <= 8'h10;
    flt0.ov <= 1'b1;
    cyc(2);
    chk(gate0, 2'b01);
    chk(fsp_oe, 2'b01);
    flt0.ov <= 1'b0;
    cyc(5);
    chk(gate0.hs, 1'b0);
    bus(0, frs_pkg::ADDR_LOG, 0);
    chk(rd[16], 1'b1);
    results;
  end
endmodule
`default_nettype wire
